// File: vaeic_ctrl.sv
// Alarm and error insert control for one tributary channel.
// Assumes a V5 strobe and receive status from logic on clk;
// ring REI input and reference clock arrive from pins.
//
// Notes on behaviour
// R1 - Insert-select clear: REI follows received BIP-2 errors, or ring.
// R2 - Insert-select set: software makes REI or BIP-2 errors.
// R3 - Ring REI output always carries the required REI value.
// R4 - V5 bit 3 from BIP-2 errors, or ring input in ring mode.
// R5 - Unequipped label with enable set makes DS1 AIS to DS1 side.
// R6 - Software clears unequipped enable if unequipped; uses line AIS.
// R7 - Send-REI, select, idle one, ring off: REI count times.
// R8 - Send-REI, select, idle zero, ring off: REI continuously.
// R9 - Send-system-AIS fills mapped payload with all ones.
// R10 - Send-BIP-error with select: inverted BIP-2 count times.
// R11 - Software writes zero to reserved bit 4 of send register.
// R12 - Send-line-AIS: coder emits AIS, reference clock over 31.5.
// R13 - Yellow on signaling highway in byte-sync mode, not data_comm_mode.
// R14 - Send-RFI sets RFI bit in every outgoing V5.
// R15 - Send-VT-AIS replaces whole mapped tributary with all ones.
// R16 - Counted bursts take one count per V5; stop until re-armed.
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps

`include "vaeic_regs.svh"

module vaeic_ctrl (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic [7:0]           regAddr,
    input  wire vaeic_pkg::vaeic_byte_t regWrData,
    input  wire logic                 regWr,
    input  wire logic                 regRd,
    output vaeic_pkg::vaeic_byte_t    regRdData,
    input  wire logic                 v5Strobe,
    input  wire logic                 rxBipError,
    input  wire logic                 rxUnequipped,
    input  wire logic                 ringRemoteErrorValue,
    input  wire logic                 systemReferenceClock,
    output logic                      v5ReiBit,
    output logic                      v5RfiBit,
    output logic                      bipInvert,
    output logic                      ringRemoteErrorOut,
    output logic                      payloadAllOnes,
    output logic                      tributaryAllOnes,
    output logic                      lineAis,
    output logic                      lineAisTick,
    output logic                      txSignalingYellow
);
    import vaeic_pkg::*;

    vaeic_byte_t  inselReg;
    vaeic_byte_t  sendReg;
    vaeic_byte_t  configReg;
    vaeic_byte_t  countReg;
    vaeic_byte_t  reiRemainReg;
    vaeic_byte_t  bipRemainReg;
    vaeic_burst_t reiStateReg;
    vaeic_burst_t reiStateNext;
    vaeic_burst_t bipStateReg;
    vaeic_burst_t bipStateNext;
    vaeic_byte_t  rdDataNext;
    logic         ringSync1Reg;
    logic         ringSync2Reg;
    logic         refSync1Reg;
    logic         refSync2Reg;
    logic         refLastReg;
    logic [5:0]   divCountReg;
    logic         reiSelect;
    logic         ringMode;
    logic         idleCtl;
    logic         dataComm;
    logic         sendRei;
    logic         sendBip;
    logic         reiArm;
    logic         bipArm;
    logic         swRei;
    logic         requiredRei;
    logic         refEdge;

    // Masked value for a register write; reserved bits stay zero
    function automatic vaeic_byte_t wrValue(
        input vaeic_byte_t data,
        input vaeic_byte_t mask
    );
        wrValue = data & mask;
    endfunction

    // True when a write strobe hits the given offset
    function automatic logic wrHit(
        input logic [7:0] addr,
        input logic [7:0] off,
        input logic       wr
    );
        wrHit = wr && (addr == off);
    endfunction

    assign reiSelect = inselReg[`VAEIC_INSEL_REISEL];
    assign ringMode  = configReg[`VAEIC_CFG_RING];
    assign idleCtl   = configReg[`VAEIC_CFG_IDLE];
    assign dataComm  = configReg[`VAEIC_CFG_DATA_COMM_MODE];
    assign sendRei   = sendReg[`VAEIC_SEND_REI];
    assign sendBip   = sendReg[`VAEIC_SEND_BIPERR];

    // Burst arms on a zero-to-one write of its send bit
    assign reiArm = wrHit(regAddr, `VAEIC_OFF_SEND, regWr)
                    && regWrData[`VAEIC_SEND_REI] && !sendRei;
    assign bipArm = wrHit(regAddr, `VAEIC_OFF_SEND, regWr)
                    && regWrData[`VAEIC_SEND_BIPERR] && !sendBip;

    // Register writes; reserved bits such as send bit 4 read zero [R11]
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            inselReg <= `VAEIC_RST_BYTE;
            sendReg <= `VAEIC_RST_BYTE;
            configReg <= `VAEIC_RST_BYTE;
            countReg <= `VAEIC_RST_BYTE;
        end else if (wrHit(regAddr, `VAEIC_OFF_INSEL, regWr)) begin
            inselReg <= wrValue(regWrData, `VAEIC_INSEL_MASK);
        end else if (wrHit(regAddr, `VAEIC_OFF_SEND, regWr)) begin
            sendReg <= wrValue(regWrData, `VAEIC_SEND_MASK);
        end else if (wrHit(regAddr, `VAEIC_OFF_CONFIG, regWr)) begin
            configReg <= wrValue(regWrData, `VAEIC_CFG_MASK);
        end else if (wrHit(regAddr, `VAEIC_OFF_COUNT, regWr)) begin
            countReg <= regWrData;
        end
    end

    // REI burst sequencer
    always_comb begin
        reiStateNext = reiStateReg;
        case (reiStateReg)
            BURST_IDLE: begin
                if (reiArm) begin
                    reiStateNext = BURST_RUN;
                end
            end
            BURST_RUN: begin
                if (!sendRei) begin
                    reiStateNext = reiArm ? BURST_RUN : BURST_IDLE;
                end else if (reiRemainReg == 8'h00) begin
                    reiStateNext = BURST_DONE;
                end
            end
            BURST_DONE: begin
                if (!sendRei) begin
                    reiStateNext = reiArm ? BURST_RUN : BURST_IDLE;
                end
            end
            default: begin
                reiStateNext = BURST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reiStateReg <= BURST_IDLE;
        end else begin
            reiStateReg <= reiStateNext;
        end
    end

    // One count per V5 while inserting [R16]
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reiRemainReg <= 8'h00;
        end else if (reiArm) begin
            reiRemainReg <= countReg;
        end else if (reiStateReg == BURST_RUN && v5Strobe
                     && reiSelect && idleCtl && !ringMode
                     && reiRemainReg != 8'h00) begin
            reiRemainReg <= reiRemainReg - 8'h01;
        end
    end

    // Inverted BIP-2 burst sequencer
    always_comb begin
        bipStateNext = bipStateReg;
        case (bipStateReg)
            BURST_IDLE: begin
                if (bipArm) begin
                    bipStateNext = BURST_RUN;
                end
            end
            BURST_RUN: begin
                if (!sendBip) begin
                    bipStateNext = bipArm ? BURST_RUN : BURST_IDLE;
                end else if (bipRemainReg == 8'h00) begin
                    bipStateNext = BURST_DONE;
                end
            end
            BURST_DONE: begin
                if (!sendBip) begin
                    bipStateNext = bipArm ? BURST_RUN : BURST_IDLE;
                end
            end
            default: begin
                bipStateNext = BURST_IDLE;
            end
        endcase
    end

    // New burst only after clear and set again [R10]
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bipStateReg <= BURST_IDLE;
        end else begin
            bipStateReg <= bipStateNext;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bipRemainReg <= 8'h00;
        end else if (bipArm) begin
            bipRemainReg <= countReg;
        end else if (bipStateReg == BURST_RUN && v5Strobe
                     && reiSelect && bipRemainReg != 8'h00) begin
            bipRemainReg <= bipRemainReg - 8'h01; // [R16]
        end
    end

    // Software REI: counted with idle one, continuous with idle zero
    always_comb begin
        swRei = 1'b0;
        if (sendRei && !ringMode) begin
            if (idleCtl) begin
                swRei = (reiStateReg == BURST_RUN)
                        && (reiRemainReg != 8'h00); // [R7]
            end else begin
                swRei = 1'b1; // [R8]
            end
        end
    end

    // Locally required REI, sent to the ring whatever the select
    always_comb begin
        if (reiSelect) begin
            requiredRei = swRei; // [R2]
        end else begin
            requiredRei = rxBipError; // [R1]
        end
    end

    // Ring REI input passes two flip-flops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ringSync1Reg <= 1'b0;
            ringSync2Reg <= 1'b0;
        end else begin
            ringSync1Reg <= ringRemoteErrorValue;
            ringSync2Reg <= ringSync1Reg;
        end
    end

    // Outgoing overhead bits, registered on each V5
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            v5ReiBit <= 1'b0;
            v5RfiBit <= 1'b0;
            bipInvert <= 1'b0;
        end else if (v5Strobe) begin
            if (ringMode) begin
                v5ReiBit <= ringSync2Reg; // [R1] [R4]
            end else begin
                v5ReiBit <= requiredRei; // [R4]
            end
            v5RfiBit <= sendReg[`VAEIC_SEND_RFI]; // [R14]
            bipInvert <= reiSelect && bipStateReg == BURST_RUN
                         && bipRemainReg != 8'h00; // [R10]
        end
    end

    // Ring REI, all-ones forcing, line AIS and yellow levels
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ringRemoteErrorOut <= 1'b0;
            payloadAllOnes <= 1'b0;
            tributaryAllOnes <= 1'b0;
            lineAis <= 1'b0;
            txSignalingYellow <= 1'b0;
        end else begin
            ringRemoteErrorOut <= requiredRei; // [R3]
            payloadAllOnes <= sendReg[`VAEIC_SEND_SYSAIS]; // [R9]
            tributaryAllOnes <= sendReg[`VAEIC_SEND_VTAIS]; // [R15]
            lineAis <= sendReg[`VAEIC_SEND_LINEAIS]
                       || (inselReg[`VAEIC_INSEL_UNEQAIS]
                           && rxUnequipped); // [R5] [R12]
            // Yellow only in byte-synchronous mode
            txSignalingYellow <= sendReg[`VAEIC_SEND_YELLOW]
                                 && !dataComm; // [R13]
        end
    end

    // Reference clock passes two flip-flops before edge detection
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            refSync1Reg <= 1'b0;
            refSync2Reg <= 1'b0;
            refLastReg <= 1'b0;
        end else begin
            refSync1Reg <= systemReferenceClock;
            refSync2Reg <= refSync1Reg;
            refLastReg <= refSync2Reg;
        end
    end
    assign refEdge = refSync2Reg ^ refLastReg;
    // Both edges counted: 63 half periods make 31.5 periods
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            divCountReg <= 6'd0;
        end else if (!lineAis) begin
            divCountReg <= 6'd0;
        end else if (refEdge) begin
            if (divCountReg == `VAEIC_LINE_DIV_HALF) begin
                divCountReg <= 6'd0;
            end else begin
                divCountReg <= divCountReg + 6'd1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lineAisTick <= 1'b0;
        end else begin
            lineAisTick <= lineAis && refEdge
                           && divCountReg == `VAEIC_LINE_DIV_HALF; // [R12]
        end
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        rdDataNext = 8'h00;
        if (regAddr == `VAEIC_OFF_INSEL) begin
            rdDataNext = inselReg;
        end else if (regAddr == `VAEIC_OFF_SEND) begin
            rdDataNext = sendReg;
        end else if (regAddr == `VAEIC_OFF_CONFIG) begin
            rdDataNext = configReg;
        end else if (regAddr == `VAEIC_OFF_COUNT) begin
            rdDataNext = countReg;
        end else if (regAddr == `VAEIC_OFF_STATUS) begin
            rdDataNext = {4'h0, bipStateReg == BURST_DONE,
                          bipStateReg == BURST_RUN,
                          reiStateReg == BURST_DONE,
                          reiStateReg == BURST_RUN};
        end else if (regAddr == `VAEIC_OFF_REMAIN) begin
            rdDataNext = reiRemainReg;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (regRd) begin
            regRdData <= rdDataNext;
        end else begin
            regRdData <= 8'h00;
        end
    end

endmodule

// File: vaeic_regs.svh
// Register offsets, field positions, reset values, timing counts.
// Included by the alarm/error insert control block.
`ifndef VAEIC_REGS_SVH
`define VAEIC_REGS_SVH

`define VAEIC_OFF_INSEL      8'h02
`define VAEIC_OFF_SEND       8'h03
`define VAEIC_OFF_CONFIG     8'h10
`define VAEIC_OFF_COUNT      8'h11
`define VAEIC_OFF_STATUS     8'h12
`define VAEIC_OFF_REMAIN     8'h13

`define VAEIC_INSEL_REISEL   1
`define VAEIC_INSEL_UNEQAIS  0
`define VAEIC_INSEL_MASK     8'h03

`define VAEIC_SEND_REI       7
`define VAEIC_SEND_SYSAIS    6
`define VAEIC_SEND_BIPERR    5
`define VAEIC_SEND_LINEAIS   3
`define VAEIC_SEND_YELLOW    2
`define VAEIC_SEND_RFI       1
`define VAEIC_SEND_VTAIS     0
`define VAEIC_SEND_MASK      8'hef

`define VAEIC_CFG_RING       0
`define VAEIC_CFG_IDLE       1
`define VAEIC_CFG_DATA_COMM_MODE    2
`define VAEIC_CFG_MASK       8'h07

`define VAEIC_RST_BYTE       8'h00
`define VAEIC_LINE_DIV_HALF  6'd62

`endif

// File: vaeic_pkg.sv
// Types shared by the alarm/error insert control block.
// Offsets and counts live in vaeic_regs.svh.
package vaeic_pkg;

    typedef logic [7:0] vaeic_byte_t;

    typedef enum logic [1:0] {
        BURST_IDLE,
        BURST_RUN,
        BURST_DONE
    } vaeic_burst_t;

endpackage

// File: vaeic_ctrl_props.sv
// Port checker for the alarm/error insert control block.
// Bound to vaeic_ctrl; mirrors register writes to predict outputs.
`timescale 1ns/10ps
module vaeic_ctrl_props (
    input logic                   clk,
    input logic                   sys_rst,
    input logic [7:0]             regAddr,
    input vaeic_pkg::vaeic_byte_t regWrData,
    input logic                   regWr,
    input logic                   regRd,
    input vaeic_pkg::vaeic_byte_t regRdData,
    input logic                   v5Strobe,
    input logic                   rxBipError,
    input logic                   rxUnequipped,
    input logic                   v5ReiBit,
    input logic                   v5RfiBit,
    input logic                   bipInvert,
    input logic                   payloadAllOnes,
    input logic                   tributaryAllOnes,
    input logic                   lineAis,
    input logic                   lineAisTick,
    input logic                   txSignalingYellow
);
    import vaeic_pkg::*;
    vaeic_byte_t inselReg;
    vaeic_byte_t sendReg;
    vaeic_byte_t cfgReg;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            inselReg <= 8'h00;
            sendReg <= 8'h00;
            cfgReg <= 8'h00;
        end else if (regWr) begin
            if (regAddr == 8'h02)
                inselReg <= regWrData & 8'h03;
            if (regAddr == 8'h03)
                sendReg <= regWrData & 8'hef;
            if (regAddr == 8'h10)
                cfgReg <= regWrData & 8'h07;
        end
    end
    sequence reiFromBip;
        v5Strobe && !cfgReg[0] && !inselReg[1];
    endsequence
    sequence reiSteady;
        v5Strobe && inselReg[1] && sendReg[7] && cfgReg[1:0] == 2'h0;
    endsequence
    rdIdle_a: assert property (
        !$past(regRd) |-> regRdData == 8'h00)
        else $error("read data not zero outside read");
    rdBack_a: assert property (
        regRd && regAddr == 8'h03 |=> regRdData == $past(sendReg))
        else $error("send register read back wrong");
    rfiStrobe_a: assert property (
        v5Strobe |=> v5RfiBit == $past(sendReg[1]))
        else $error("RFI bit does not follow send bit");
    v5Hold_a: assert property (
        !v5Strobe |=> $stable({v5ReiBit, v5RfiBit, bipInvert}))
        else $error("V5 bits changed without strobe");
    reiBip_a: assert property (
        reiFromBip |=> v5ReiBit == $past(rxBipError))
        else $error("REI does not follow received errors");
    reiCont_a: assert property (
        reiSteady |=> v5ReiBit)
        else $error("continuous REI missing");
    sysAis_a: assert property (
        payloadAllOnes == $past(sendReg[6]))
        else $error("payload all ones wrong");
    vtAis_a: assert property (
        tributaryAllOnes == $past(sendReg[0]))
        else $error("tributary all ones wrong");
    lineAis_a: assert property (
        lineAis == $past(sendReg[3] || (inselReg[0] && rxUnequipped)))
        else $error("line AIS level wrong");
    yellow_a: assert property (
        txSignalingYellow == $past(sendReg[2] && !cfgReg[2]))
        else $error("yellow level wrong");
    tickPulse_a: assert property (
        lineAisTick |=> !lineAisTick)
        else $error("line AIS tick longer than one cycle");
endmodule

// File: vaeic_far_model.sv
// Far-side model: V5 frame timing, received status and line pins.
// Bench sets strobe spacing and error levels; runs on clk.
`timescale 1ns/10ps
module vaeic_far_model (
    input  logic       clk,
    input  logic       sys_rst,
    input  logic [7:0] gap,
    input  logic       bipErr,
    input  logic       ringIn,
    output logic       v5Strobe,
    output logic       rxBipError,
    output logic       ringRemoteErrorValue,
    output logic       systemReferenceClock
);
    logic [7:0] cntReg;
    // Free-running reference, unrelated in phase to clk
    initial begin
        systemReferenceClock = 1'h0;
        forever #5 systemReferenceClock = ~systemReferenceClock;
    end
    // Strobe every gap+1 cycles; a gap of zero makes strobes adjacent
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cntReg <= 8'h00;
            v5Strobe <= 1'h0;
        end else if (cntReg >= gap) begin
            cntReg <= 8'h00;
            v5Strobe <= 1'h1;
        end else begin
            cntReg <= cntReg + 8'h01;
            v5Strobe <= 1'h0;
        end
    end
    assign rxBipError = bipErr;
    assign ringRemoteErrorValue = ringIn;
endmodule

// File: vaeic_ctrl_tb.sv
// Self-checking bench for the alarm/error insert control block.
// Far-side model supplies V5 strobes, reference clock and ring pin.
`timescale 1ns/10ps
module vaeic_ctrl_tb;
    import vaeic_pkg::*;
    logic        clk = 1'h0;
    logic        sys_rst, regWr, regRd, rxUnequipped, bipErr, ringIn;
    logic [7:0]  regAddr, gap;
    vaeic_byte_t regWrData, regRdData;
    logic        v5Strobe, rxBipError, ringRemoteErrorValue;
    logic        systemReferenceClock, v5ReiBit, v5RfiBit, bipInvert;
    logic        ringRemoteErrorOut, payloadAllOnes, tributaryAllOnes;
    logic        lineAis, lineAisTick, txSignalingYellow;
    int          failures, checks, cyc, got, i;

    vaeic_far_model u_far (.clk(clk), .sys_rst(sys_rst), .gap(gap),
        .bipErr(bipErr), .ringIn(ringIn), .v5Strobe(v5Strobe),
        .rxBipError(rxBipError),
        .ringRemoteErrorValue(ringRemoteErrorValue),
        .systemReferenceClock(systemReferenceClock));
    vaeic_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .v5Strobe(v5Strobe),
        .rxBipError(rxBipError), .rxUnequipped(rxUnequipped),
        .ringRemoteErrorValue(ringRemoteErrorValue),
        .systemReferenceClock(systemReferenceClock), .v5ReiBit(v5ReiBit),
        .v5RfiBit(v5RfiBit), .bipInvert(bipInvert),
        .ringRemoteErrorOut(ringRemoteErrorOut),
        .payloadAllOnes(payloadAllOnes),
        .tributaryAllOnes(tributaryAllOnes), .lineAis(lineAis),
        .lineAisTick(lineAisTick), .txSignalingYellow(txSignalingYellow));

    always #2 clk = ~clk;

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'h1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        regRd <= 1'h1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'h0;
        @(negedge clk);
        check("regRdData", regRdData, exp);
    endtask

    // Counts set REI or BIP-invert bits over n V5 strobes
    task automatic countV5(input int n, input bit bip, output int ones);
        ones = 0;
        repeat (n) begin
            @(posedge clk);
            while (v5Strobe !== 1'h1) @(posedge clk);
            @(negedge clk);
            if ((bip ? bipInvert : v5ReiBit) === 1'h1) ones++;
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            tally_and_finish;
        end
    end

    initial begin
        sys_rst = 1'h1;
        {regWr, regRd, rxUnequipped, bipErr, ringIn} = 5'h00;
        regAddr = 8'h00;
        regWrData = 8'h00;
        gap = 8'h02;
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        rd(8'h03, 8'h00);
        rd(8'h10, 8'h00);
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h07);
        wr(8'h02, 8'hff);
        rd(8'h02, 8'h03);
        wr(8'h03, 8'hff); // Reserved bit deliberately set, must drop
        rd(8'h03, 8'hef);
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h00);
        wr(8'h03, 8'h00);
        // Counted REI, re-armed with prompt then slow strobes
        wr(8'h11, 8'h03);
        wr(8'h02, 8'h02);
        wr(8'h10, 8'h02);
        for (i = 0; i < 2; i++) begin
            gap <= i ? 8'h09 : 8'h02;
            wr(8'h03, 8'h80);
            countV5(6, 0, got);
            check("reiBurst", got[7:0], 8'h03);
            wr(8'h03, 8'h00);
        end
        rd(8'h11, 8'h03);
        rd(8'h13, 8'h00);
        // BIP burst; rewriting without clearing must not re-arm
        wr(8'h03, 8'h20);
        countV5(5, 1, got);
        check("bipBurst", got[7:0], 8'h03);
        rd(8'h12, 8'h08);
        wr(8'h03, 8'h20);
        countV5(4, 1, got);
        check("bipRearm", got[7:0], 8'h00);
        wr(8'h10, 8'h00);
        wr(8'h03, 8'h80);
        countV5(6, 0, got);
        check("reiSteady", got[7:0], 8'h06);
        // REI from received errors
        wr(8'h03, 8'h00);
        wr(8'h02, 8'h00);
        bipErr <= 1'h1;
        countV5(4, 0, got);
        check("reiFromBip", got[7:0], 8'h04);
        check("ringOut", {7'h00, ringRemoteErrorOut}, 8'h01);
        @(posedge clk);
        bipErr <= 1'h0;
        countV5(3, 0, got);
        check("reiNoBip", got[7:0], 8'h00);
        // Ring mode overrides the select
        @(posedge clk);
        ringIn <= 1'h1;
        wr(8'h02, 8'h02);
        wr(8'h10, 8'h01);
        countV5(4, 0, got);
        check("reiRing", got[7:0], 8'h04);
        @(posedge clk);
        ringIn <= 1'h0;
        wr(8'h10, 8'h00);
        wr(8'h02, 8'h00);
        wr(8'h03, 8'h4f);
        repeat (2) @(negedge clk);
        check("levels", {4'h0, payloadAllOnes, tributaryAllOnes, lineAis,
              txSignalingYellow}, 8'h0f);
        countV5(1, 0, got);
        check("rfi", {7'h00, v5RfiBit}, 8'h01);
        // Tick spacing: 63 reference edges of 5 ns, about 79 cycles
        for (i = 0; i < 200 && lineAisTick !== 1'h1; i++) @(negedge clk);
        for (i = 1; i < 200; i++) begin
            @(negedge clk);
            if (lineAisTick === 1'h1) break;
        end
        check("tickGap", {7'h00, i >= 77 && i <= 80}, 8'h01);
        wr(8'h10, 8'h04);
        repeat (2) @(negedge clk);
        check("yellowDatacom", {7'h00, txSignalingYellow}, 8'h00);
        // Unequipped label to line AIS, then enable cleared
        wr(8'h03, 8'h00);
        wr(8'h02, 8'h01);
        rxUnequipped <= 1'h1;
        repeat (3) @(negedge clk);
        check("uneqAis", {7'h00, lineAis}, 8'h01);
        wr(8'h02, 8'h00);
        repeat (2) @(negedge clk);
        check("uneqOff", {7'h00, lineAis}, 8'h00);
        tally_and_finish;
    end
endmodule

bind vaeic_ctrl vaeic_ctrl_props u_props (.clk(clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .v5Strobe(v5Strobe),
    .rxBipError(rxBipError), .rxUnequipped(rxUnequipped),
    .v5ReiBit(v5ReiBit), .v5RfiBit(v5RfiBit), .bipInvert(bipInvert),
    .payloadAllOnes(payloadAllOnes), .tributaryAllOnes(tributaryAllOnes),
    .lineAis(lineAis), .lineAisTick(lineAisTick),
    .txSignalingYellow(txSignalingYellow));
